// file: logic/bop_l0_pkg.sv
// Constants for the level 0 brownout configuration bank
package brownout_l0_pkg;
    // Register offsets on page 0
    localparam logic [7:0] ADDR_ATK_RLS = 8'h2F;
    localparam logic [7:0] ADDR_RRATE_ATTN = 8'h30;
    localparam logic [7:0] ADDR_THRESH = 8'h31;
    localparam logic [7:0] ADDR_HOLD_CTL = 8'h32;
    // Reset values
    localparam logic [7:0] RST_ATK_RLS = 8'h06;
    localparam logic [7:0] RST_RRATE_ATTN = 8'h3E;
    localparam logic [7:0] RST_THRESH = 8'h37;
    localparam logic [7:0] RST_HOLD_CTL = 8'h20;
    // Writable bit masks; others read zero
    localparam logic [7:0] MASK_ATK_RLS = 8'hFE;
    localparam logic [7:0] MASK_FULL = 8'hFF;
    // Field positions
    localparam int RATE_LSB = 5;
    localparam int STEP_LSB = 1;
    localparam int DIS_BIT = 4;
    localparam int HLD_BIT = 0;
    // Threshold code limits per supply and other field codes
    localparam logic [7:0] BAT_TH_MAX = 8'h38;
    localparam logic [7:0] PS_TH_MAX = 8'hD2;
    localparam logic [4:0] ATTN_MIN_CODE = 5'h0C;
    localparam logic [2:0] HOLD_INF = 3'h7;
    localparam logic [2:0] LLVL_NONE = 3'h4;
    localparam logic [2:0] LLVL_L0 = 3'h0;
    // Clock and interval tables
    localparam int CLK_MHZ = 100;
    localparam int ATK_NS [8] = '{2500, 5000, 10000, 25000, 50000, 100000, 100000, 100000};
    localparam int REL_MS [8] = '{5, 10, 25, 50, 100, 250, 500, 1000};
    localparam int HOLD_MS [8] = '{100, 100, 100, 250, 500, 1000, 2000, 2000};
    localparam int CYC_PER_MS = CLK_MHZ * 1000;
endpackage

// file: logic/brownout_level0_config_bank.sv
// Level 0 brownout configuration bank with its gain limiter
//
// Summary of operation
// R1 - Attack rate code picks step interval
// R2 - Release step code picks gain step
// R3 - Release rate code picks release interval
// R4 - Attenuation limited, codes below 0xC reserved
// R5 - Battery threshold linear, above 0x38 zero
// R6 - Power stage threshold linear, above 0xD2 zero
// R7 - Hold time codes, code 7 until clear
// R8 - Disable bit turns level 0 off
// R9 - Status hold bit freezes status readback
// R10 - Clearing hold resets and resumes status
// R11 - Defined reset values for all registers
// R12 - Lowest level code, 4 means none
// R13 - Attack, hold, then release gain
// R14 - Reserved bits read zero; hold control bits 3-1 keep what is written
`timescale 1ns/100ps
module brownout_level0_config_bank
    import brownout_l0_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic threshold_source_select,
    input wire logic [7:0] supply_code,
    input wire logic hold_clear,
    output logic [7:0] reg_rdata,
    output logic [5:0] gain_reduction_step,
    output logic level0_attacking,
    output logic status_hold,
    output logic [2:0] lowest_level_status,
    output logic [7:0] lowest_supply_status,
    output logic brownout_state_status
);
    // Overview of this bank
    // Four byte registers sit at page 0 offsets 0x2F to 0x32
    // Writes land on the edge that samples reg_wr
    // Reads return data one edge after reg_rd
    // Read data stays put until the next read strobe
    // Unmapped offsets read zero and swallow writes
    // Bit 0 of the first register is reserved and reads zero
    // Bits 3-1 of the hold control register keep what is written
    //
    // The limiter walks idle, attack, hold and release
    // Attack adds one step per attack interval
    // Attack stops at the attenuation limit or on recovery
    // Hold keeps the gain for the chosen hold time
    // Hold code 7 waits for hold_clear instead of a timer
    // Release takes release-step units off per interval
    // A fresh dip below threshold restarts the attack
    // Disabling the level mid-attack drops straight to release
    //
    // Status outputs follow the limiter while unheld
    // Setting the hold bit freezes them for a clean read
    // Clearing it resets them and lets them move again
    // Status outputs lag the hold bit by one edge
    //
    // Limitations
    // Supply and threshold share one code scale here
    // Release steps are whole attack steps, not dB
    // Reserved rate and hold codes map to safe neighbours
    // Long intervals need 32-bit timers at this clock
    // Only level 0 lives here; other levels are elsewhere
    // No bus error is raised for unmapped offsets
    //
    // Register copies
    logic [7:0] atk_rls_q;
    logic [7:0] rrate_attn_q;
    logic [7:0] thresh_q;
    logic [7:0] hold_ctl_q;

    // Fields are plain slices of the stored bytes
    // Decoding here keeps the limiter free of bit positions
    // Decoded fields
    logic [2:0] level0_attack_rate;
    logic [3:0] level0_release_step;
    logic [2:0] level0_release_rate;
    logic [4:0] level0_max_attenuation;
    logic [2:0] level0_hold_time;
    logic level0_disable;
    assign level0_attack_rate = atk_rls_q[RATE_LSB +: 3]; // see R1
    assign level0_release_step = atk_rls_q[STEP_LSB +: 4]; // see R2
    assign level0_release_rate = rrate_attn_q[RATE_LSB +: 3]; // see R3
    assign level0_max_attenuation = rrate_attn_q[4:0];
    assign level0_hold_time = hold_ctl_q[RATE_LSB +: 3];
    assign level0_disable = hold_ctl_q[DIS_BIT]; // see R8

    // Write path
    // Masking at write time means readback needs no masking
    // A write and a read in one cycle return the old value
    // Software sees the new value on the following read
    // Register writes; reserved bit 0 of first register dropped
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            atk_rls_q <= RST_ATK_RLS; // see R11
            rrate_attn_q <= RST_RRATE_ATTN;
            thresh_q <= RST_THRESH;
            hold_ctl_q <= RST_HOLD_CTL;
        end else if (reg_wr) begin
            case (reg_addr)
                ADDR_ATK_RLS: atk_rls_q <= reg_wdata & MASK_ATK_RLS; // see R14
                ADDR_RRATE_ATTN: rrate_attn_q <= reg_wdata;
                ADDR_THRESH: thresh_q <= reg_wdata;
                ADDR_HOLD_CTL: hold_ctl_q <= reg_wdata & MASK_FULL; // Bits 3-1 store
                default: ;
            endcase
        end
    end

    // Read path
    // Registered so the output comes straight from a flip-flop
    // Costs one cycle of latency on every read
    // Read data registered, unmapped reads zero
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                ADDR_ATK_RLS: reg_rdata <= atk_rls_q;
                ADDR_RRATE_ATTN: reg_rdata <= rrate_attn_q;
                ADDR_THRESH: reg_rdata <= thresh_q;
                ADDR_HOLD_CTL: reg_rdata <= hold_ctl_q;
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    // Trip detection
    // The source select only moves the top of the valid range
    // A zero threshold can never be crossed from above
    // So an out-of-range code simply switches the level off
    // The disable bit gates the trip, not the registers
    // Threshold validity: codes past range mean zero volts, never trips
    logic thresh_zero;
    always_comb begin
        if (threshold_source_select) begin
            thresh_zero = (thresh_q > PS_TH_MAX); // see R6
        end else begin
            thresh_zero = (thresh_q > BAT_TH_MAX); // see R5
        end
    end
    // Both supplies share one code scale, so compare codes directly
    logic below_th;
    assign below_th = !thresh_zero && (supply_code < thresh_q) && !level0_disable; // see R8

    // Effective limit; reserved codes clamp at minimum legal setting
    logic [5:0] attn_limit;
    assign attn_limit = (level0_max_attenuation < ATTN_MIN_CODE) ?
        {1'b0, ATTN_MIN_CODE} : {1'b0, level0_max_attenuation}; // see R4

    // Interval lookup
    // Tables hold times; cycles follow from the clock rate
    // Changing the clock only needs the package constant
    // Counts are recomputed each cycle from live fields
    // A rate change mid-interval takes effect at once
    // Interval counts in cycles
    logic [31:0] atk_cycles;
    logic [31:0] rel_cycles;
    logic [31:0] hold_cycles;
    assign atk_cycles = 32'(ATK_NS[level0_attack_rate] * CLK_MHZ / 1000); // see R1
    assign rel_cycles = 32'(REL_MS[level0_release_rate] * CYC_PER_MS); // see R3
    assign hold_cycles = 32'(HOLD_MS[level0_hold_time] * CYC_PER_MS); // see R7

    // Limiter state encoding
    // One-hot codes keep each state decode to a single bit
    // Illegal codes fall back to idle through the default
    // Limiter states
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_ATTACK = 4'b0010,
        ST_HOLD = 4'b0100,
        ST_RELEASE = 4'b1000
    } lim_state_e;
    lim_state_e state_q;
    logic [31:0] timer_q;
    logic [5:0] step_q;
    // Release step in attack units: coarse approximation of dB table
    logic [5:0] rel_amt;
    assign rel_amt = (level0_release_step == 4'h0) ? 6'h01 : {2'h0, level0_release_step}; // see R2

    // Limiter sequencer
    // One shared timer serves attack, hold and release
    // The timer clears on every state change
    // Compare uses timer plus one so a count of N takes N cycles
    // Attack checks recovery only at step boundaries
    // That keeps each attack step a whole interval long
    // Hold and release re-enter attack on a new dip
    // Release ends in idle once the gain is fully restored
    // Attack, hold, release sequence
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
            timer_q <= 32'h0;
            step_q <= 6'h00;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    timer_q <= 32'h0;
                    if (below_th) begin
                        state_q <= ST_ATTACK; // see R13
                    end
                end
                ST_ATTACK: begin
                    if (level0_disable) begin
                        state_q <= ST_RELEASE;
                        timer_q <= 32'h0;
                    end else if (timer_q + 32'h1 >= atk_cycles) begin
                        timer_q <= 32'h0;
                        if (step_q < attn_limit) begin
                            step_q <= step_q + 6'h01; // see R13
                        end
                        if (!below_th || step_q + 6'h01 >= attn_limit) begin
                            state_q <= ST_HOLD;
                        end
                    end else begin
                        timer_q <= timer_q + 32'h1;
                    end
                end
                ST_HOLD: begin
                    if (below_th) begin
                        state_q <= ST_ATTACK;
                        timer_q <= 32'h0;
                    end else if (level0_hold_time == HOLD_INF) begin
                        if (hold_clear) begin
                            state_q <= ST_RELEASE; // see R7
                            timer_q <= 32'h0;
                        end
                    end else if (timer_q + 32'h1 >= hold_cycles) begin
                        state_q <= ST_RELEASE; // see R7
                        timer_q <= 32'h0;
                    end else begin
                        timer_q <= timer_q + 32'h1;
                    end
                end
                ST_RELEASE: begin
                    if (below_th) begin
                        state_q <= ST_ATTACK;
                        timer_q <= 32'h0;
                    end else if (step_q == 6'h00) begin
                        state_q <= ST_IDLE;
                    end else if (timer_q + 32'h1 >= rel_cycles) begin
                        timer_q <= 32'h0;
                        step_q <= (step_q > rel_amt) ? step_q - rel_amt : 6'h00; // see R13
                    end else begin
                        timer_q <= timer_q + 32'h1;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Output stage
    // Both outputs lag the sequencer by one cycle
    // Kept registered so pins see no decode glitches
    // Limiter outputs registered
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            gain_reduction_step <= 6'h00;
            level0_attacking <= 1'b0;
        end else begin
            gain_reduction_step <= step_q;
            level0_attacking <= (state_q == ST_ATTACK);
        end
    end

    // Status capture
    // Lowest supply only ever moves down while tracking
    // Lowest level moves to level 0 on any attack while tracking
    // The registered hold copy marks the falling edge
    // Clear wins over tracking in that one cycle
    // Tracking resumes on the edge after the clear
    // Status tracking; frozen while hold bit set, reset on its fall
    logic hold_bit;
    assign hold_bit = hold_ctl_q[HLD_BIT];
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            status_hold <= 1'b0;
            lowest_level_status <= LLVL_NONE; // see R12
            lowest_supply_status <= 8'hFF;
            brownout_state_status <= 1'b0;
        end else begin
            status_hold <= hold_bit; // see R9
            if (status_hold && !hold_bit) begin
                lowest_level_status <= LLVL_NONE; // see R10
                lowest_supply_status <= 8'hFF;
                brownout_state_status <= 1'b0;
            end else if (!hold_bit) begin
                // Readback not valid here, values keep moving
                brownout_state_status <= (state_q != ST_IDLE);
                if (state_q == ST_ATTACK) begin
                    lowest_level_status <= LLVL_L0; // see R12
                end
                if (supply_code < lowest_supply_status) begin
                    lowest_supply_status <= supply_code;
                end
            end
        end
    end
endmodule

// file: tb/bop_l0_properties.sv
// Port checker for the level 0 brownout bank
`timescale 1ns/100ps
module brownout_l0_properties
    import brownout_l0_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [5:0] gain_reduction_step,
    input wire logic level0_attacking,
    input wire logic status_hold,
    input wire logic [2:0] lowest_level_status,
    input wire logic [7:0] lowest_supply_status,
    input wire logic brownout_state_status
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    a_hold_bit_copy: assert property (reg_wr && reg_addr == ADDR_HOLD_CTL |=> ##1 status_hold == $past(reg_wdata[0], 2))
        else $error("status hold not copied");
    a_unmapped_zero: assert property (reg_rd && (reg_addr < ADDR_ATK_RLS || reg_addr > ADDR_HOLD_CTL) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_reserved_bit: assert property (reg_rd && reg_addr == ADDR_ATK_RLS |=> !reg_rdata[0])
        else $error("reserved bit reads one");
    a_rdata_stands: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved");
    a_attack_in_state: assert property (level0_attacking && !status_hold && !$fell(status_hold) |-> brownout_state_status)
        else $error("attack outside active state");
    a_gain_one_step: assert property (1 |=> gain_reduction_step <= 6'($past(gain_reduction_step) + 6'h01))
        else $error("gain jumped");
    a_attack_no_drop: assert property (level0_attacking |=> gain_reduction_step >= $past(gain_reduction_step))
        else $error("gain fell in attack");
    a_lowest_level: assert property (level0_attacking && !status_hold |-> ##[1:3] lowest_level_status == LLVL_L0)
        else $error("lowest level not zero");
    a_freeze_status: assert property (status_hold ##1 status_hold |-> $stable(lowest_supply_status))
        else $error("held status moved");
    a_clear_resets: assert property ($fell(status_hold) && !brownout_state_status |-> ##[0:2] lowest_level_status == LLVL_NONE)
        else $error("status not reset");
    c_attack: cover property ($rose(level0_attacking));
    c_hold_set: cover property ($rose(status_hold));
    c_hold_clr: cover property ($fell(status_hold));
endmodule

// file: tb/brownout_level0_config_bank_tb_top.sv
// Self-checking bench for the level 0 brownout bank
`timescale 1ns/100ps
module brownout_level0_config_bank_tb_top;
    import brownout_l0_pkg::*;
    logic sys_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, src = 0, hold_clear = 0;
    logic [7:0] reg_addr = 0, reg_wdata = 0, supply = 8'hFF, reg_rdata, lss;
    logic [5:0] gain;
    logic att, shld, bss;
    logic [2:0] lls;
    logic [7:0] mdl [4];
    int err_count = 0, total_checks = 0;
    brownout_level0_config_bank i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .threshold_source_select(src),
        .supply_code(supply), .hold_clear(hold_clear), .reg_rdata(reg_rdata), .gain_reduction_step(gain),
        .level0_attacking(att), .status_hold(shld), .lowest_level_status(lls),
        .lowest_supply_status(lss), .brownout_state_status(bss));
    // Free-running 100 MHz clock
    initial forever #5 sys_clk = ~sys_clk;
    task automatic finish_test();
        if (err_count == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // Expected readback: reserved bit 0 of the first register drops
    function automatic logic [7:0] exp_of(input logic [7:0] a, input logic [7:0] d);
        return (a == ADDR_ATK_RLS) ? (d & MASK_ATK_RLS) : d;
    endfunction
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 0;
        if (a >= ADDR_ATK_RLS && a <= ADDR_HOLD_CTL) mdl[a - ADDR_ATK_RLS] = exp_of(a, d);
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        reg_rd <= 1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 0;
        #1;
        chk(reg_rdata, (a >= ADDR_ATK_RLS && a <= ADDR_HOLD_CTL) ? mdl[a - ADDR_ATK_RLS] : 8'h00);
    endtask
    // Synchronous reset, model back to documented values
    task automatic rst_dut();
        @(posedge sys_clk);
        sys_rst <= 1;
        supply <= 8'hFF;
        src <= 0;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 0;
        mdl = '{RST_ATK_RLS, RST_RRATE_ATTN, RST_THRESH, RST_HOLD_CTL};
    endtask
    // Bounded wait for the attack flag; a hang ends the run
    task automatic wait_att(input int n);
        while (att !== 1'b1 && n > 0) begin
            cyc(1);
            n--;
        end
        chk(att, 1'b1);
        if (att !== 1'b1) finish_test();
    endtask
    initial begin
        void'($urandom(92));
        rst_dut();
        for (int a = 0; a < 4; a++) rd(ADDR_ATK_RLS + 8'(a));
        chk(lls, LLVL_NONE);
        chk(lss, 8'hFF);
        // Random traffic over the bank and its neighbours; supply stays high so nothing trips
        repeat (40) begin
            hold_clear <= 1'($urandom_range(0, 1));
            wr(8'($urandom_range(8'h2E, 8'h34)), 8'($urandom));
            rd(reg_addr);
            chk(shld, mdl[3][HLD_BIT]);
        end
        rst_dut();
        supply <= 8'h10;
        wait_att(5);
        cyc(238);
        chk(gain, 6'h00);
        cyc(20);
        chk(gain, 6'h01);
        chk(lls, LLVL_L0);
        chk(lss, 8'h10);
        wr(ADDR_HOLD_CTL, 8'h21);
        supply <= 8'h05;
        cyc(5);
        chk(lss, 8'h10);
        chk(bss, 1'b1);
        rst_dut();
        wr(ADDR_HOLD_CTL, 8'h30);
        supply <= 8'h00;
        cyc(20);
        chk(att, 1'b0);
        rst_dut();
        wr(ADDR_THRESH, 8'h39);
        supply <= 8'h00;
        cyc(20);
        chk(att, 1'b0);
        src <= 1;
        wait_att(5);
        rst_dut();
        src <= 1;
        wr(ADDR_THRESH, 8'hD3);
        supply <= 8'h00;
        cyc(20);
        chk(att, 1'b0);
        rst_dut();
        wr(ADDR_RRATE_ATTN, 8'h00);
        wr(ADDR_ATK_RLS, 8'h00);
        supply <= 8'h10;
        cyc(3300);
        chk(gain, {2'h0, ATTN_MIN_CODE});
        rst_dut();
        wr(ADDR_HOLD_CTL, 8'h21);
        wr(ADDR_HOLD_CTL, 8'h20);
        cyc(3);
        chk(lls, LLVL_NONE);
        finish_test();
    end
endmodule
bind brownout_level0_config_bank brownout_l0_properties i_props (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .gain_reduction_step(gain_reduction_step), .level0_attacking(level0_attacking),
    .status_hold(status_hold), .lowest_level_status(lowest_level_status),
    .lowest_supply_status(lowest_supply_status), .brownout_state_status(brownout_state_status));
